// file: inc/nv_ctrl_pkg.sv
// How it works
// - each byte write is self-timed, programming lasts a fixed 4 ms interval
// - a started write finishes even if reset arrives during programming
// - starting a write stalls the cpu for two clock cycles
// - starting a read stalls the cpu for four clock cycles
// - address register selects one of 256 bytes, 0 through 255
// - data register supplies write data and receives read data
// - control register bits 7..4 always read zero
// - ready irq held while write strobe is zero, enable and global enable set
// - write arm bit clears itself four clocks after software sets it
// - write strobe starts programming only while arm is set, else ignored
// - write strobe clears itself when the programming interval ends
// - read strobe while no write is busy fetches byte into data register and clears in one instruction
package nv_ctrl_pkg;
    // ------------------------------------------------------------
    // register map (i/o space offsets)
    // ------------------------------------------------------------
    localparam logic [5:0] NV_ADDRESS_OFS = 6'h1E;
    localparam logic [5:0] NV_DATA_OFS    = 6'h1D;
    localparam logic [5:0] NV_CONTROL_OFS = 6'h1C;
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int READ_STROBE_BIT  = 0;
    localparam int WRITE_STROBE_BIT = 1;
    localparam int WRITE_ARM_BIT    = 2;
    localparam int READY_IRQ_EN_BIT = 3;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ           = 40_000_000;
    localparam int PROG_TIME_US     = 4000;
    localparam int PROG_CYCLES      = PROG_TIME_US * (CLK_HZ / 1_000_000);
    localparam int ARM_CYCLES       = 4;
    localparam int WRITE_STALL      = 2;
    localparam int READ_STALL       = 4;
endpackage

// file: sim/nv_access_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nv_access_ctrl_tb;
    // short programming interval keeps the run brief
    localparam int         PC  = 20;
    localparam logic [5:0] AOF = nv_ctrl_pkg::NV_ADDRESS_OFS;
    localparam logic [5:0] DOF = nv_ctrl_pkg::NV_DATA_OFS;
    localparam logic [5:0] COF = nv_ctrl_pkg::NV_CONTROL_OFS;
    logic       clk_in           = 1'b0;
    logic       arst_n_in        = 1'b0;
    logic [5:0] io_addr_in       = 6'h00;
    logic       io_wr_in         = 1'b0;
    logic       io_rd_in         = 1'b0;
    logic [7:0] io_wdata_in      = 8'h00;
    logic       global_irq_en_in = 1'b0;
    logic [7:0] io_rdata_out;
    logic       cpu_stall_out;
    logic       ready_irq_out;
    logic       prog_busy_out;
    int         fail_count       = 0;
    int         cmp_count        = 0;
    logic [7:0] rd;

    always #12.5 clk_in = ~clk_in;

    nv_access_ctrl #(.PROG_CYCLES(PC)) dut_u (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .io_addr_in(io_addr_in), .io_wr_in(io_wr_in),
        .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
        .global_irq_en_in(global_irq_en_in), .cpu_stall_out(cpu_stall_out),
        .ready_irq_out(ready_irq_out), .prog_busy_out(prog_busy_out));

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic io_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        io_addr_in  = a;
        io_wdata_in = d;
        io_wr_in    = 1'b1;
        @(posedge clk_in);
        #1;
        io_wr_in = 1'b0;
    endtask
    task automatic io_read(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        io_addr_in = a;
        io_rd_in   = 1'b1;
        @(posedge clk_in);
        #1;
        io_rd_in = 1'b0;
        d        = io_rdata_out;
    endtask
    // stall is sampled over six cycles so a too-long stall shows up too
    task automatic stall_len(input int exp);
        int c;
        c = 0;
        repeat (6) begin
            if (cpu_stall_out === 1'b1) c++;
            @(posedge clk_in);
            #1;
        end
        check("stall_cycles", exp[7:0], c[7:0]);
    endtask
    task automatic wait_idle(input int lo, input int hi);
        int c;
        c = 0;
        while (prog_busy_out !== 1'b0 && c < 1000) begin
            @(posedge clk_in);
            #1;
            c++;
        end
        check("busy_span_ok", 8'h01, {7'h00, (c >= lo && c <= hi)});
    endtask
    task automatic nv_write(input logic [7:0] a, input logic [7:0] d);
        io_write(AOF, a);
        io_write(DOF, d);
        io_write(COF, 8'h04);
        io_write(COF, 8'h02);
        stall_len(2);
    endtask
    task automatic nv_read(input logic [7:0] a, output logic [7:0] d);
        io_write(AOF, a);
        io_write(COF, 8'h01);
        stall_len(4);
        io_read(DOF, d);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        io_read(COF, rd);
        check("ctrl_reset", 8'h00, rd);
        io_read(6'h00, rd);
        check("unmapped", 8'h00, rd);
        check("irq_idle", 8'h00, {7'h00, ready_irq_out});
    endtask
    task automatic t_write_read();
        nv_write(8'h00, 8'h5A);
        io_read(COF, rd);
        check("ctrl_busy", 8'h02, rd);
        wait_idle(PC - 7, PC - 3);
        io_read(COF, rd);
        check("ctrl_done", 8'h00, rd);
        nv_write(8'hFF, 8'hC3);
        wait_idle(PC - 7, PC - 3);
        nv_read(8'h00, rd);
        check("byte_lo", 8'h5A, rd);
        nv_read(8'hFF, rd);
        check("byte_hi", 8'hC3, rd);
    endtask
    task automatic t_refused();
        io_write(COF, 8'h02);
        check("no_arm", 8'h00, {7'h00, prog_busy_out});
        io_write(COF, 8'h04);
        repeat (5) @(posedge clk_in);
        io_read(COF, rd);
        check("arm_clear", 8'h00, rd);
        io_write(COF, 8'h02);
        check("arm_late", 8'h00, {7'h00, prog_busy_out});
    endtask
    task automatic t_repeat_strobe();
        nv_write(8'h10, 8'h11);
        io_write(COF, 8'h04);
        io_write(COF, 8'h02);
        wait_idle(PC - 9, PC - 3);
    endtask
    task automatic t_irq();
        global_irq_en_in = 1'b1;
        io_write(COF, 8'h08);
        @(posedge clk_in);
        #1;
        check("irq_on", 8'h01, {7'h00, ready_irq_out});
        global_irq_en_in = 1'b0;
        @(posedge clk_in);
        #1;
        check("irq_global", 8'h00, {7'h00, ready_irq_out});
        io_write(AOF, 8'h20);
        io_write(DOF, 8'h77);
        io_write(COF, 8'h0C);
        io_write(COF, 8'h0A);
        global_irq_en_in = 1'b1;
        @(posedge clk_in);
        #1;
        check("irq_busy", 8'h00, {7'h00, ready_irq_out});
        wait_idle(0, PC);
        @(posedge clk_in);
        #1;
        check("irq_ready", 8'h01, {7'h00, ready_irq_out});
        io_write(COF, 8'h00);
        @(posedge clk_in);
        #1;
        check("irq_off", 8'h00, {7'h00, ready_irq_out});
    endtask
    // reset lands mid-programming; the byte must still arrive
    task automatic t_reset_mid();
        nv_write(8'h30, 8'h3C);
        arst_n_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        check("busy_in_reset", 8'h01, {7'h00, prog_busy_out});
        arst_n_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        wait_idle(0, PC);
        nv_read(8'h30, rd);
        check("byte_after_reset", 8'h3C, rd);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_in);
        #1;
        arst_n_in = 1'b1;
        repeat (3) @(posedge clk_in);
        t_reset_values();
        t_write_read();
        t_refused();
        t_repeat_strobe();
        t_irq();
        t_reset_mid();
        summarize();
    end

    initial begin
        #100000;
        fail_count++;
        summarize();
    end
endmodule
`default_nettype wire

// file: src/nv_access_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module nv_access_ctrl #(
    parameter int PROG_CYCLES = nv_ctrl_pkg::PROG_CYCLES
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    // i/o space register port
    input  wire logic [5:0] io_addr_in,
    input  wire logic       io_wr_in,
    input  wire logic       io_rd_in,
    input  wire logic [7:0] io_wdata_in,
    output logic      [7:0] io_rdata_out,
    // core status
    input  wire logic       global_irq_en_in,
    output logic            cpu_stall_out,
    output logic            ready_irq_out,
    output logic            prog_busy_out
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    logic rst_n;
    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_LOAD = 3'h2,
        ST_PROG = 3'h4
    } prog_state_t;

    prog_state_t prog_state_reg, prog_state_next;
    logic [23:0] prog_cnt_reg, prog_cnt_next;
    logic [7:0]  index_reg, index_next;
    logic [7:0]  value_reg, value_next;
    logic        arm_reg, arm_next;
    logic [2:0]  arm_cnt_reg, arm_cnt_next;
    logic        irq_en_reg, irq_en_next;
    logic [2:0]  stall_cnt_reg, stall_cnt_next;
    logic        read_pend_reg, read_pend_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        irq_reg, irq_next;
    logic [7:0]  store_rd_data;
    logic        store_wr;
    logic        busy_reg;

    wire wr_addr_hit = io_wr_in && (io_addr_in == nv_ctrl_pkg::NV_ADDRESS_OFS);
    wire wr_data_hit = io_wr_in && (io_addr_in == nv_ctrl_pkg::NV_DATA_OFS);
    wire wr_ctl_hit  = io_wr_in && (io_addr_in == nv_ctrl_pkg::NV_CONTROL_OFS);
    wire busy        = (prog_state_reg != ST_IDLE);
    wire [7:0] control_view = {4'h0, irq_en_reg, arm_reg, busy, 1'b0};

    nv_byte_store u_store (
        .clk_in      (clk_in),
        .wr_en_in    (store_wr),
        .wr_addr_in  (index_reg),
        .wr_data_in  (value_reg),
        .rd_addr_in  (index_reg),
        .rd_data_out (store_rd_data)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        prog_state_next = prog_state_reg;
        prog_cnt_next   = prog_cnt_reg;
        index_next      = index_reg;
        value_next      = value_reg;
        arm_next        = arm_reg;
        arm_cnt_next    = arm_cnt_reg;
        irq_en_next     = irq_en_reg;
        stall_cnt_next  = (stall_cnt_reg != 3'h0) ? stall_cnt_reg - 3'h1 : 3'h0;
        read_pend_next  = 1'b0;
        store_wr        = 1'b0;
        // address and data simply load; a write in flight is not protected
        if (wr_addr_hit) begin
            index_next = io_wdata_in;
        end
        if (wr_data_hit) begin
            value_next = io_wdata_in;
        end
        // arm timeout
        if (arm_reg) begin
            if (arm_cnt_reg == 3'(nv_ctrl_pkg::ARM_CYCLES - 1)) begin
                arm_next = 1'b0;
            end else begin
                arm_cnt_next = arm_cnt_reg + 3'h1;
            end
        end
        if (wr_ctl_hit) begin
            irq_en_next = io_wdata_in[nv_ctrl_pkg::READY_IRQ_EN_BIT];
            if (io_wdata_in[nv_ctrl_pkg::WRITE_ARM_BIT] && !io_wdata_in[nv_ctrl_pkg::WRITE_STROBE_BIT]) begin
                arm_next     = 1'b1;
                arm_cnt_next = 3'h0;
            end
            if (io_wdata_in[nv_ctrl_pkg::WRITE_STROBE_BIT] && arm_reg && !busy) begin
                prog_state_next = ST_LOAD;
                arm_next        = 1'b0;
                stall_cnt_next  = 3'(nv_ctrl_pkg::WRITE_STALL);
            end else if (io_wdata_in[nv_ctrl_pkg::READ_STROBE_BIT] && !busy) begin
                read_pend_next = 1'b1;
                stall_cnt_next = 3'(nv_ctrl_pkg::READ_STALL);
            end
        end
        unique case (prog_state_reg)
            ST_IDLE: begin
                prog_cnt_next = 24'h0;
            end
            ST_LOAD: begin
                prog_state_next = ST_PROG;
                prog_cnt_next   = 24'h0;
            end
            ST_PROG: begin
                if (prog_cnt_reg == 24'(PROG_CYCLES - 1)) begin
                    store_wr        = 1'b1;
                    prog_state_next = ST_IDLE;
                end else begin
                    prog_cnt_next = prog_cnt_reg + 24'h1;
                end
            end
            default: begin
                prog_state_next = ST_IDLE;
            end
        endcase
        // read: store read register holds the byte at index one clock later
        if (read_pend_reg) begin
            value_next = store_rd_data;
        end
        rdata_next = 8'h00;
        if (io_rd_in) begin
            unique case (io_addr_in)
                nv_ctrl_pkg::NV_ADDRESS_OFS: rdata_next = index_reg;
                nv_ctrl_pkg::NV_DATA_OFS:    rdata_next = value_reg;
                nv_ctrl_pkg::NV_CONTROL_OFS: rdata_next = control_view;
                default:                     rdata_next = 8'h00;
            endcase
        end
        // while reset holds, an idle machine may not leave idle
        if (!rst_n && prog_state_reg == ST_IDLE) begin
            prog_state_next = ST_IDLE;
        end
        irq_next = irq_en_reg && global_irq_en_in && (prog_state_next == ST_IDLE);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // programming state ignores reset so a started write finishes; busy follows it through reset
    always_ff @(posedge clk_in) begin
        prog_state_reg <= prog_state_next;
        prog_cnt_reg   <= prog_cnt_next;
        index_reg      <= index_next;
        value_reg      <= value_next;
        busy_reg       <= (prog_state_next != ST_IDLE);
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            arm_reg       <= 1'b0;
            arm_cnt_reg   <= 3'h0;
            irq_en_reg    <= 1'b0;
            stall_cnt_reg <= 3'h0;
            read_pend_reg <= 1'b0;
            rdata_reg     <= 8'h00;
            irq_reg       <= 1'b0;
        end else begin
            arm_reg       <= arm_next;
            arm_cnt_reg   <= arm_cnt_next;
            irq_en_reg    <= irq_en_next;
            stall_cnt_reg <= stall_cnt_next;
            read_pend_reg <= read_pend_next;
            rdata_reg     <= rdata_next;
            irq_reg       <= irq_next;
        end
    end

    logic stall_reg;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            stall_reg <= 1'b0;
        end else begin
            stall_reg <= (stall_cnt_next != 3'h0);
        end
    end

    assign io_rdata_out  = rdata_reg;
    assign cpu_stall_out = stall_reg;
    assign ready_irq_out = irq_reg;
    assign prog_busy_out = busy_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    a_arm_timeout: assert property ($rose(arm_reg) |-> ##[1:4] !arm_reg) else $error("arm not cleared");
    a_arm_hold: assert property ($rose(arm_reg) && !wr_ctl_hit |=> arm_reg) else $error("arm dropped early");
    a_strobe_start: assert property (wr_ctl_hit && io_wdata_in[1] && arm_reg && !busy |=> prog_state_reg == ST_LOAD) else $error("write not started");
    a_strobe_ignore: assert property (wr_ctl_hit && io_wdata_in[1] && !arm_reg && !busy |=> !busy) else $error("unarmed write started");
    a_write_stall: assert property (prog_state_reg == ST_LOAD |-> stall_reg ##1 stall_reg ##1 !stall_reg) else $error("write stall length");
    a_read_stall: assert property (read_pend_reg |-> stall_reg [*4] ##1 !stall_reg) else $error("read stall length");
    a_read_data: assert property (read_pend_reg |=> value_reg == $past(store_rd_data)) else $error("read data not loaded");
    a_ctl_upper: assert property (io_rd_in && io_addr_in == nv_ctrl_pkg::NV_CONTROL_OFS |=> io_rdata_out[7:4] == 4'h0) else $error("reserved bits set");
    a_irq_level: assert property (##1 ready_irq_out == $past(irq_en_reg && global_irq_en_in && prog_state_next == ST_IDLE)) else $error("irq level wrong");
    a_prog_end: assert property (store_wr |=> !busy) else $error("strobe not cleared");
    a_busy_view: assert property (io_rd_in && io_addr_in == nv_ctrl_pkg::NV_CONTROL_OFS && busy |=> io_rdata_out[1]) else $error("strobe not shown");
    a_irq_busy: assert property (prog_busy_out |-> !ready_irq_out) else $error("irq while busy");

    c_write: cover property (store_wr);
    c_read: cover property (read_pend_reg);
    c_arm_lapse: cover property ($fell(arm_reg) && !busy);
    c_irq: cover property ($rose(ready_irq_out));
endmodule
`default_nettype wire

// file: src/nv_byte_store.sv
`timescale 1ns/1ps
`default_nettype none
module nv_byte_store (
    // clock
    input  wire logic       clk_in,
    // write port
    input  wire logic       wr_en_in,
    input  wire logic [7:0] wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    // read port
    input  wire logic [7:0] rd_addr_in,
    output logic      [7:0] rd_data_out
);
    logic [7:0] mem [0:255];
    logic [7:0] rd_reg;

    // no reset: contents are nonvolatile
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_reg <= mem[rd_addr_in];
    end

    assign rd_data_out = rd_reg;
endmodule
`default_nettype wire
